// ==== shared/rsc_pkg.sv ====
// Operation
// - master reset from pin, supply monitor or watchdog
// - master reset clears all but the RAMs and programming entry state
// - reset pin synchronised, async assert, clocked release
// - all ten pins inputs during master reset
// - radio held powered down during master reset
// - pins stay inputs until software changes them
// - pull-ups on by reset, software may disable
// - long reset hold opens programming command acceptance
// - programming mode only after unlock command
// - slave-output pin input until unlock command seen
// - normal mode: radio, converter powered by software
// - sleep keeps only RAMs, supply monitor, timer
// - wake pin wakes, polarity chosen by software
// - leave sleep on timer, reset pin, power cycle
// - supply monitor always on, low power in sleep
// - wake-up timer period 1 to 256 seconds
// - wake pin is level sensitive only
// - wait oscillator start-up before running again; a wake through master reset runs once master reset ends
package rsc_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WUT_PERIOD = 8'h04;
  localparam logic [7:0] REG_PIN_DIR = 8'h08;
  localparam logic [7:0] REG_PULLUP = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_FIELD_LSB = 1;
  localparam int CTRL_FIELD_W = 5;

  // pin counts of the two general-purpose ports
  localparam int TWO_BIT_PORT_W = 2;
  localparam int EIGHT_BIT_PORT_W = 8;
  localparam int PIN_W = TWO_BIT_PORT_W + EIGHT_BIT_PORT_W;

  // reset values
  localparam logic [PIN_W-1:0] PIN_DIR_RST = 10'h000;
  localparam logic [PIN_W-1:0] PULLUP_RST = 10'h3ff;
  localparam logic [7:0] WUT_PERIOD_RST = 8'h00;

  // timing: system clock and the times derived from it
  localparam int CLK_HZ = 25_000_000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int OSC_STARTUP_US = 2000;
  localparam int OSC_STARTUP_CYCLES = OSC_STARTUP_US * (CLK_HZ / 1_000_000);
  localparam int PROG_HOLD_MS = 10;
  localparam int PROG_HOLD_CYCLES = PROG_HOLD_MS * (CLK_HZ / 1000);

  // unlock opcode value is arbitrary
  localparam logic [7:0] PROG_UNLOCK_CMD = 8'ha5;

  // software controlled power and wake options, msb first
  typedef struct packed {
    logic wake_pin_en;
    logic wake_pol_high;
    logic wut_en;
    logic adc_en;
    logic rf_en;
  } rsc_ctrl_t;

  localparam rsc_ctrl_t CTRL_RST = '0;

  // power states
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OSC_WAIT = 2'b10
  } rsc_state_t;

endpackage : rsc_pkg

// ==== core/rsc_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_sync
(
  // clock
  input wire logic clk_i,
  // asynchronous active low reset pin
  input wire logic pin_rst_n_i,
  // synchronised level, low while reset is held
  output logic sync_rst_n_o
);

  logic meta_r;
  logic sync_r;

  // asserts at once, releases after two edges so release never meets setup
  always_ff @(posedge clk_i or negedge pin_rst_n_i)
  begin
    if (!pin_rst_n_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= 1'b1;
      sync_r <= meta_r;
    end
  end

  assign sync_rst_n_o = sync_r;

endmodule : rsc_pin_sync
`default_nettype wire

// ==== core/rsc_wake_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsc_wake_timer
#(
  parameter int SEC_CYCLES = rsc_pkg::SEC_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [7:0] period_i,
  // one-cycle pulse when the period has run out
  output logic expire_o
);

  generate
    if (SEC_CYCLES < 2)
    begin : g_bad
      $error("rsc_wake_timer: SEC_CYCLES must be at least 2");
    end
  endgenerate

  logic [31:0] pre_r;
  logic [31:0] pre_nxt;
  logic [7:0] sec_r;
  logic [7:0] sec_nxt;
  logic expire_r;
  logic expire_nxt;

  // prescaler to whole seconds, counted seconds compare against period
  always_comb
  begin
    pre_nxt = pre_r;
    sec_nxt = sec_r;
    expire_nxt = 1'b0;
    if (!run_i)
    begin
      pre_nxt = '0;
      sec_nxt = '0;
    end
    else if (pre_r == 32'(SEC_CYCLES - 1))
    begin
      pre_nxt = '0;
      if (sec_r == period_i) // period field holds seconds minus one
      begin
        expire_nxt = 1'b1;
        sec_nxt = '0;
      end
      else
        sec_nxt = sec_r + 8'h01;
    end
    else
      pre_nxt = pre_r + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r <= '0;
      sec_r <= '0;
      expire_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      sec_r <= sec_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire_o = expire_r;

endmodule : rsc_wake_timer
`default_nettype wire

// ==== core/rsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsc_top
#(
  parameter int SEC_CYCLES = rsc_pkg::SEC_CYCLES,
  parameter int OSC_STARTUP_CYCLES = rsc_pkg::OSC_STARTUP_CYCLES,
  parameter int PROG_HOLD_CYCLES = rsc_pkg::PROG_HOLD_CYCLES,
  parameter logic [7:0] PROG_UNLOCK_CMD = rsc_pkg::PROG_UNLOCK_CMD
)
(
  // clock and system reset
  input wire logic clk_i,
  input wire logic rst_i,
  // reset sources
  input wire logic ext_rst_n_i,
  input wire logic bod_low_i,
  input wire logic wdt_timeout_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // wake source
  input wire logic wake_interrupt_pin_i,
  // programming path from the serial slave
  input wire logic spi_byte_valid_i,
  input wire logic [7:0] spi_byte_i,
  input wire logic spi_miso_drive_i,
  output logic spi_miso_oe_o,
  output logic prog_accept_o,
  output logic prog_mode_o,
  // general-purpose pin control
  output logic [rsc_pkg::TWO_BIT_PORT_W-1:0] two_bit_pin_port_oe_o,
  output logic [rsc_pkg::EIGHT_BIT_PORT_W-1:0] eight_bit_pin_port_oe_o,
  output logic [rsc_pkg::PIN_W-1:0] pin_pullup_en_o,
  // power and reset controls
  output logic master_rst_o,
  output logic cpu_run_o,
  output logic osc_en_o,
  output logic rf_pwr_en_o,
  output logic adc_pwr_en_o,
  output logic wut_pwr_en_o,
  output logic bod_low_power_o
);

  localparam int PW = rsc_pkg::PIN_W;

  generate
    if (OSC_STARTUP_CYCLES < 1 || PROG_HOLD_CYCLES < 1)
    begin : g_bad
      $error("rsc_top: timing counts must be at least 1");
    end
  endgenerate

  // byte-lane merge for a wishbone write
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : wb_merge

  logic pin_rst_n;
  logic master_rst;
  logic wut_expire;

  // reset pin synchroniser: asserts immediately, releases on the clock
  rsc_pin_sync u_pin_sync
  (
    .clk_i(clk_i),
    .pin_rst_n_i(ext_rst_n_i),
    .sync_rst_n_o(pin_rst_n)
  );

  // any source holds the chip in master reset; RAMs never see this line
  assign master_rst = rst_i | ~pin_rst_n | bod_low_i | wdt_timeout_i;

  // software state: control, timer period, pin direction, pull-ups
  rsc_pkg::rsc_ctrl_t ctrl_r;
  rsc_pkg::rsc_ctrl_t ctrl_nxt;
  logic [7:0] wut_period_r;
  logic [7:0] wut_period_nxt;
  logic [PW-1:0] pin_dir_r;
  logic [PW-1:0] pin_dir_nxt;
  logic [PW-1:0] pullup_r;
  logic [PW-1:0] pullup_nxt;
  logic sleep_req;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  rsc_pkg::rsc_state_t state_r;
  rsc_pkg::rsc_state_t state_nxt;
  logic prog_accept_r;
  logic prog_unlock_r;

  logic wb_req;
  logic wb_wr;
  logic [31:0] wr_word;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr = wb_req & wb_we_i;

  // bus decode; ack one cycle after the request, unmapped reads give zero
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    wut_period_nxt = wut_period_r;
    pin_dir_nxt = pin_dir_r;
    pullup_nxt = pullup_r;
    sleep_req = 1'b0;
    ack_nxt = wb_req;
    rdat_nxt = rdat_r;
    wr_word = '0;
    if (wb_req && wb_adr_i == rsc_pkg::REG_CTRL)
    begin
      wr_word = wb_merge({26'h0, ctrl_r, 1'b0}, wb_dat_i, wb_sel_i);
      if (wb_wr)
      begin
        ctrl_nxt = rsc_pkg::rsc_ctrl_t'(wr_word[rsc_pkg::CTRL_FIELD_LSB +: rsc_pkg::CTRL_FIELD_W]);
        sleep_req = wr_word[rsc_pkg::CTRL_SLEEP_BIT];
      end
      rdat_nxt = {26'h0, ctrl_r, 1'b0};
    end
    else if (wb_req && wb_adr_i == rsc_pkg::REG_WUT_PERIOD)
    begin
      wr_word = wb_merge({24'h0, wut_period_r}, wb_dat_i, wb_sel_i);
      if (wb_wr)
        wut_period_nxt = wr_word[7:0];
      rdat_nxt = {24'h0, wut_period_r};
    end
    else if (wb_req && wb_adr_i == rsc_pkg::REG_PIN_DIR)
    begin
      wr_word = wb_merge({22'h0, pin_dir_r}, wb_dat_i, wb_sel_i);
      if (wb_wr)
        pin_dir_nxt = wr_word[PW-1:0];
      rdat_nxt = {22'h0, pin_dir_r};
    end
    else if (wb_req && wb_adr_i == rsc_pkg::REG_PULLUP)
    begin
      wr_word = wb_merge({22'h0, pullup_r}, wb_dat_i, wb_sel_i);
      if (wb_wr)
        pullup_nxt = wr_word[PW-1:0];
      rdat_nxt = {22'h0, pullup_r};
    end
    else if (wb_req && wb_adr_i == rsc_pkg::REG_STATUS)
      rdat_nxt = {27'h0, wake_interrupt_pin_i, prog_unlock_r, prog_accept_r, state_r};
    else if (wb_req)
      rdat_nxt = '0;
  end

  // every software-written register returns to its reset value on master reset
  always_ff @(posedge clk_i)
  begin
    if (master_rst)
    begin
      ctrl_r <= rsc_pkg::CTRL_RST;
      wut_period_r <= rsc_pkg::WUT_PERIOD_RST;
      pin_dir_r <= rsc_pkg::PIN_DIR_RST;
      pullup_r <= rsc_pkg::PULLUP_RST;
      ack_r <= 1'b0;
      rdat_r <= '0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      wut_period_r <= wut_period_nxt;
      pin_dir_r <= pin_dir_nxt;
      pullup_r <= pullup_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // wake-up timer only runs while asleep and enabled
  rsc_wake_timer #(.SEC_CYCLES(SEC_CYCLES)) u_wake_timer
  (
    .clk_i(clk_i),
    .rst_i(master_rst),
    .run_i(state_r == rsc_pkg::ST_SLEEP && ctrl_r.wut_en),
    .period_i(wut_period_r),
    .expire_o(wut_expire)
  );

  // wake pin compared as a level, never as an edge, so a held pin rewakes
  logic wake_pin_active;
  assign wake_pin_active = ctrl_r.wake_pin_en &
                           (wake_interrupt_pin_i == ctrl_r.wake_pol_high);

  // power state machine; reset pin and power cycle wake through master reset
  logic [31:0] osc_cnt_r;
  logic [31:0] osc_cnt_nxt;

  always_comb
  begin
    state_nxt = state_r;
    osc_cnt_nxt = osc_cnt_r;
    case (state_r)
      rsc_pkg::ST_NORMAL:
      begin
        if (sleep_req)
          state_nxt = rsc_pkg::ST_SLEEP;
      end
      rsc_pkg::ST_SLEEP:
      begin
        osc_cnt_nxt = '0;
        if (wake_pin_active || wut_expire)
          state_nxt = rsc_pkg::ST_OSC_WAIT;
      end
      rsc_pkg::ST_OSC_WAIT:
      begin
        osc_cnt_nxt = osc_cnt_r + 32'h1;
        if (osc_cnt_r == 32'(OSC_STARTUP_CYCLES - 1))
          state_nxt = rsc_pkg::ST_NORMAL;
      end
      default:
        state_nxt = rsc_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (master_rst)
    begin
      state_r <= rsc_pkg::ST_NORMAL;
      osc_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      osc_cnt_r <= osc_cnt_nxt;
    end
  end

  // programming entry survives the held reset, so only power, rst_i or releasing the pin clear it
  logic [31:0] hold_cnt_r;
  logic [31:0] hold_cnt_nxt;
  logic prog_accept_nxt;
  logic prog_unlock_nxt;

  always_comb
  begin
    hold_cnt_nxt = hold_cnt_r;
    prog_accept_nxt = prog_accept_r;
    prog_unlock_nxt = prog_unlock_r;
    if (pin_rst_n)
    begin
      hold_cnt_nxt = '0;
      prog_accept_nxt = 1'b0;
      prog_unlock_nxt = 1'b0;
    end
    else if (!prog_accept_r)
    begin
      hold_cnt_nxt = hold_cnt_r + 32'h1;
      if (hold_cnt_r == 32'(PROG_HOLD_CYCLES - 1))
        prog_accept_nxt = 1'b1;
    end
    else if (spi_byte_valid_i && spi_byte_i == PROG_UNLOCK_CMD)
      prog_unlock_nxt = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || bod_low_i)
    begin
      hold_cnt_r <= '0;
      prog_accept_r <= 1'b0;
      prog_unlock_r <= 1'b0;
    end
    else
    begin
      hold_cnt_r <= hold_cnt_nxt;
      prog_accept_r <= prog_accept_nxt;
      prog_unlock_r <= prog_unlock_nxt;
    end
  end

  // registered outputs, gated by the combined reset so safe states come first; slave output gated by rst_i and power only
  logic [PW-1:0] pin_oe_r;
  logic master_rst_r;
  logic rf_pwr_r;
  logic adc_pwr_r;
  logic cpu_run_r;
  logic osc_en_r;
  logic wut_pwr_r;
  logic bod_lp_r;
  logic miso_oe_r;

  always_ff @(posedge clk_i)
  begin
    master_rst_r <= master_rst;
    pin_oe_r <= master_rst ? '0 : pin_dir_nxt;
    rf_pwr_r <= ~master_rst & (state_nxt == rsc_pkg::ST_NORMAL) & ctrl_nxt.rf_en;
    adc_pwr_r <= ~master_rst & (state_nxt == rsc_pkg::ST_NORMAL) & ctrl_nxt.adc_en;
    cpu_run_r <= ~master_rst & (state_nxt == rsc_pkg::ST_NORMAL);
    osc_en_r <= master_rst | (state_nxt != rsc_pkg::ST_SLEEP);
    wut_pwr_r <= ~master_rst & (state_nxt == rsc_pkg::ST_SLEEP) & ctrl_nxt.wut_en;
    bod_lp_r <= ~master_rst & (state_nxt == rsc_pkg::ST_SLEEP);
    miso_oe_r <= prog_unlock_nxt & spi_miso_drive_i & ~rst_i & ~bod_low_i;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign two_bit_pin_port_oe_o = pin_oe_r[rsc_pkg::TWO_BIT_PORT_W-1:0];
  assign eight_bit_pin_port_oe_o = pin_oe_r[PW-1:rsc_pkg::TWO_BIT_PORT_W];
  assign pin_pullup_en_o = pullup_r;
  assign master_rst_o = master_rst_r;
  assign cpu_run_o = cpu_run_r;
  assign osc_en_o = osc_en_r;
  assign rf_pwr_en_o = rf_pwr_r;
  assign adc_pwr_en_o = adc_pwr_r;
  assign wut_pwr_en_o = wut_pwr_r;
  assign bod_low_power_o = bod_lp_r;
  assign spi_miso_oe_o = miso_oe_r;
  assign prog_accept_o = prog_accept_r;
  assign prog_mode_o = prog_unlock_r;

endmodule : rsc_top
`default_nettype wire

// ==== bench/rsc_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsc_top_checker
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // reset sources and bus request
  input wire logic bod_low_i,
  input wire logic wdt_timeout_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  // programming path
  input wire logic spi_byte_valid_i,
  input wire logic [7:0] spi_byte_i,
  input wire logic spi_miso_oe_o,
  input wire logic prog_accept_o,
  input wire logic prog_mode_o,
  // pins and power
  input wire logic [rsc_pkg::TWO_BIT_PORT_W-1:0] two_bit_pin_port_oe_o,
  input wire logic [rsc_pkg::EIGHT_BIT_PORT_W-1:0] eight_bit_pin_port_oe_o,
  input wire logic [rsc_pkg::PIN_W-1:0] pin_pullup_en_o,
  input wire logic master_rst_o,
  input wire logic cpu_run_o,
  input wire logic osc_en_o,
  input wire logic rf_pwr_en_o,
  input wire logic adc_pwr_en_o,
  input wire logic bod_low_power_o
);
  logic req;
  logic dir_wr;
  logic slp_wr;
  logic unl;
  logic any_oe;
  // the only causes that may legally move pins, sleep or programming state
  assign req = wb_cyc_i && wb_stb_i && wb_we_i;
  assign dir_wr = req && wb_adr_i == rsc_pkg::REG_PIN_DIR;
  assign slp_wr = req && wb_adr_i == rsc_pkg::REG_CTRL && wb_dat_i[rsc_pkg::CTRL_SLEEP_BIT];
  assign unl = prog_accept_o && spi_byte_valid_i && spi_byte_i == rsc_pkg::PROG_UNLOCK_CMD;
  assign any_oe = |{eight_bit_pin_port_oe_o, two_bit_pin_port_oe_o};

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_src_forces_rst: assert property ((bod_low_i || wdt_timeout_i) |=> master_rst_o)
    else $error("source gave no master reset");
  a_rst_safe: assert property (
    master_rst_o |-> !any_oe && !rf_pwr_en_o && &pin_pullup_en_o)
    else $error("unsafe state in reset");
  a_oe_by_sw: assert property ($rose(any_oe) |-> $past(dir_wr) || $past(dir_wr, 2))
    else $error("pin output without write");
  a_accept_after_hold: assert property (
    $rose(prog_accept_o) |-> master_rst_o && $past(master_rst_o, 8))
    else $error("accept without long hold");
  a_unlock_cause: assert property ($rose(prog_mode_o) |-> $past(unl))
    else $error("programming without unlock");
  a_miso_in: assert property (!prog_mode_o && !$past(prog_mode_o) |-> !spi_miso_oe_o)
    else $error("slave output driven early");
  a_sleep_by_sw: assert property (
    $fell(cpu_run_o) && !master_rst_o |-> $past(slp_wr) || $past(slp_wr, 2))
    else $error("sleep without request");
  a_sleep_pwr_off: assert property (
    !cpu_run_o && !osc_en_o |-> !rf_pwr_en_o && !adc_pwr_en_o && bod_low_power_o)
    else $error("power left on in sleep");
  a_osc_settle: assert property ($rose(osc_en_o) && !master_rst_o |-> !cpu_run_o [*5])
    else $error("run before oscillator settled");

  // main scenarios reached
  c_unlock: cover property ($rose(prog_mode_o));
  c_sleep: cover property ($fell(cpu_run_o) && !master_rst_o);
  c_wake: cover property ($rose(cpu_run_o) && !master_rst_o);
endmodule : rsc_top_checker

bind rsc_top rsc_top_checker rsc_top_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .bod_low_i(bod_low_i), .wdt_timeout_i(wdt_timeout_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .spi_byte_valid_i(spi_byte_valid_i), .spi_byte_i(spi_byte_i), .spi_miso_oe_o(spi_miso_oe_o),
  .prog_accept_o(prog_accept_o), .prog_mode_o(prog_mode_o),
  .two_bit_pin_port_oe_o(two_bit_pin_port_oe_o), .eight_bit_pin_port_oe_o(eight_bit_pin_port_oe_o),
  .pin_pullup_en_o(pin_pullup_en_o), .master_rst_o(master_rst_o), .cpu_run_o(cpu_run_o),
  .osc_en_o(osc_en_o), .rf_pwr_en_o(rf_pwr_en_o), .adc_pwr_en_o(adc_pwr_en_o),
  .bod_low_power_o(bod_low_power_o));
`default_nettype wire

// ==== bench/rsc_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsc_partner
(
  // clock
  input wire logic clk_i,
  // pins toward the block
  output logic ext_rst_n_o,
  output logic wake_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  // idle levels: the reset pin has a pull-up
  initial
  begin
    ext_rst_n_o = 1'b1;
    wake_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // reset pin level; a long low hold opens command acceptance
  task automatic set_pin(input logic v);
    ext_rst_n_o <= v;
  endtask : set_pin
  // wake pin level
  task automatic set_wake(input logic v);
    wake_o <= v;
  endtask : set_wake
  // one whole byte as a one-cycle pulse, then one idle cycle
  task automatic send(input logic [7:0] b);
    byte_valid_o <= 1'b1;
    byte_o <= b;
    @(posedge clk_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~b; // a stale byte is not left on the line
    @(posedge clk_i);
  endtask : send
endmodule : rsc_partner
`default_nettype wire

// ==== bench/rsc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsc_top_test;
  localparam int SEC = 20;
  localparam int OSC = 8;
  logic clk_i = 1'b0;
  logic rst_i;
  logic bod;
  logic wdt;
  logic cyc;
  logic stb;
  logic we;
  logic drv;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dati;
  logic [31:0] dato;
  logic [31:0] rd;
  logic ack, pin_n, wake, bv, mso, acc, pm, mrst, run, osc, rf, adc, wake_up_timer, bodlp;
  logic [7:0] bd;
  logic [1:0] oe2;
  logic [7:0] oe8;
  logic [9:0] pu;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  rsc_top #(.SEC_CYCLES(SEC), .OSC_STARTUP_CYCLES(OSC), .PROG_HOLD_CYCLES(16)) rsc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .ext_rst_n_i(pin_n), .bod_low_i(bod), .wdt_timeout_i(wdt),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .wake_interrupt_pin_i(wake),
    .spi_byte_valid_i(bv), .spi_byte_i(bd), .spi_miso_drive_i(drv), .spi_miso_oe_o(mso),
    .prog_accept_o(acc), .prog_mode_o(pm), .two_bit_pin_port_oe_o(oe2),
    .eight_bit_pin_port_oe_o(oe8), .pin_pullup_en_o(pu), .master_rst_o(mrst), .cpu_run_o(run),
    .osc_en_o(osc), .rf_pwr_en_o(rf), .adc_pwr_en_o(adc), .wut_pwr_en_o(wake_up_timer),
    .bod_low_power_o(bodlp));
  rsc_partner rsc_partner_i (.clk_i(clk_i), .ext_rst_n_o(pin_n), .wake_o(wake),
    .byte_valid_o(bv), .byte_o(bd));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // classic single cycle; the ack delay is not assumed, the timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i); // idle cycle between requests
  endtask : wb

  // cycles until the processor runs, bounded
  task automatic wait_run;
    n = 0;
    while (run !== 1'b1 && n < 6000)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_run

  // each reset source forces the safe state and clears software settings
  task automatic t_src;
    chk("pu_rst", 10'h3ff, pu);
    wb(1'b0, 8'h20, 32'h1);
    chk("unmapped", 32'h0, rd);
    for (int s = 0; s < 3; s++)
    begin
      wb(1'b1, rsc_pkg::REG_PIN_DIR, 32'h3ff);
      wb(1'b1, rsc_pkg::REG_PULLUP, 32'h0);
      wb(1'b1, rsc_pkg::REG_CTRL, 32'h6);
      chk("sw_oe", 10'h3ff, {oe8, oe2});
      chk("sw_pwr", 2'h3, {adc, rf});
      chk("sw_pu", 10'h0, pu);
      bod <= (s == 0);
      wdt <= (s == 1);
      rsc_partner_i.set_pin(s != 2);
      repeat (3) @(posedge clk_i);
      chk("mrst", 1'b1, mrst);
      chk("rst_oe", 10'h0, {oe8, oe2});
      chk("rst_rf", 2'h0, {adc, rf});
      chk("rst_pu", 10'h3ff, pu);
      bod <= 1'b0;
      wdt <= 1'b0;
      rsc_partner_i.set_pin(1'b1);
      repeat (4) @(posedge clk_i);
      chk("mrst_end", 1'b0, mrst);
      wb(1'b0, rsc_pkg::REG_PIN_DIR, 32'h0);
      chk("dir_clr", 32'h0, rd);
    end
    // one byte lane only: the upper two pull-ups go off, the rest stay on
    sel <= 4'h2;
    wb(1'b1, rsc_pkg::REG_PULLUP, 32'h0);
    sel <= 4'hf;
    chk("sel_lane", 10'h0ff, pu);
    $display("done sources");
  endtask : t_src

  // hold, wrong byte, unlock, release
  task automatic t_prog;
    rsc_partner_i.send(rsc_pkg::PROG_UNLOCK_CMD);
    chk("early", 1'b0, pm);
    rsc_partner_i.set_pin(1'b0);
    repeat (10) @(posedge clk_i);
    chk("short_hold", 1'b0, acc);
    repeat (14) @(posedge clk_i);
    chk("accept", 1'b1, acc);
    rsc_partner_i.send(8'h5a);
    chk("wrong", 1'b0, pm);
    chk("miso_in", 1'b0, mso);
    rsc_partner_i.send(rsc_pkg::PROG_UNLOCK_CMD);
    @(posedge clk_i);
    chk("prog", 1'b1, pm);
    chk("miso_out", 1'b1, mso);
    drv <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("miso_drv", 1'b0, mso);
    drv <= 1'b1;
    rsc_partner_i.set_pin(1'b1);
    repeat (6) @(posedge clk_i);
    chk("prog_exit", 1'b0, pm);
    $display("done programming");
  endtask : t_prog

  // timer wake at the shortest, next and longest period
  task automatic t_sleep;
    int pv[3] = '{0, 1, 255};
    int e;
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, rsc_pkg::REG_WUT_PERIOD, 32'(pv[i]));
      wb(1'b1, rsc_pkg::REG_CTRL, 32'h9);
      chk("slp_run", 1'b0, run);
      chk("slp_pwr", 4'h6, {osc, wake_up_timer, bodlp, rf});
      wait_run();
      e = (pv[i] + 1) * SEC + OSC;
      chk("wut_time", 1'b1, n > e - 4 && n < e + 4);
      chk("lp_off", 1'b0, bodlp);
    end
    $display("done timer");
  endtask : t_sleep

  // pin wake in both polarities, then wake by the reset pin
  task automatic t_wake;
    wb(1'b1, rsc_pkg::REG_CTRL, 32'h31);
    repeat (10) @(posedge clk_i);
    chk("asleep", 1'b0, run);
    wb(1'b0, rsc_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    rsc_partner_i.set_wake(1'b1);
    wait_run();
    chk("hi_wake", 1'b1, n > OSC && n < OSC + 6);
    wb(1'b1, rsc_pkg::REG_CTRL, 32'h21);
    repeat (10) @(posedge clk_i);
    chk("lo_idle", 1'b0, run);
    rsc_partner_i.set_wake(1'b0);
    wait_run();
    chk("lo_wake", 1'b1, n > OSC && n < OSC + 6);
    wb(1'b1, rsc_pkg::REG_CTRL, 32'h1);
    rsc_partner_i.set_pin(1'b0);
    repeat (3) @(posedge clk_i);
    rsc_partner_i.set_pin(1'b1);
    wait_run();
    chk("rst_wake", 1'b1, run);
    $display("done wake");
  endtask : t_wake

  // counts, verdict and end of run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // hang guard, well above the longest sleep
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // reset, then the scenarios
  initial
  begin
    rst_i <= 1'b1;
    bod <= 1'b0;
    wdt <= 1'b0;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    drv <= 1'b1;
    sel <= 4'hf;
    adr <= 8'h00;
    dati <= 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_src();
    t_prog();
    t_sleep();
    t_wake();
    close_out();
  end
endmodule : rsc_top_test
`default_nettype wire
